// [src/lvs_pkg.sv]
// constants shared by the panel host controller and its helpers
package lvs_pkg;

   // ----------------------------------------------------------------
   // system clock and pixel clock
   // ----------------------------------------------------------------
   localparam int MCLK_NS = 8;
   localparam int MCLK_PS = 8000;
   localparam int PCLK_MIN_PS = 20000;
   localparam int PCLK_MAX_PS = 31250;
   localparam int PCLK_DIV = 3;

   // ----------------------------------------------------------------
   // raster, in pixel clocks and line periods
   // ----------------------------------------------------------------
   localparam int H_ACTIVE = 800;
   localparam int H_TOTAL = 1056;
   localparam int H_BLANK_MIN = 66;
   localparam int H_BLANK_MAX = 264;
   localparam int H_TOTAL_MIN = 866;
   localparam int H_TOTAL_MAX = 1064;
   localparam int V_ACTIVE = 600;
   localparam int V_TOTAL = 628;
   localparam int V_BLANK_MIN = 4;
   localparam int V_BLANK_MAX = 200;
   localparam int V_TOTAL_MIN = 604;
   localparam int V_TOTAL_MAX = 800;
   localparam int FRAME_HZ_MAX = 70;
   localparam int X_W = 11;
   localparam int Y_W = 10;

   // ----------------------------------------------------------------
   // power sequence times, in ms as printed
   // ----------------------------------------------------------------
   localparam int TP1_MIN_MS = 5;
   localparam int TP1_MAX_MS = 50;
   localparam int TP2_MIN_MS = 150;
   localparam int TP3_MIN_MS = 5;
   localparam int TP3_MAX_MS = 50;
   localparam int TP4_MIN_MS = 150;
   localparam int LOCK_MAX_MS = 1;

   // least time in ms to whole mclk cycles, rounded up
   function automatic int cyc_up(input int ms);
      cyc_up = (ms * 1000000 + MCLK_NS - 1) / MCLK_NS;
   endfunction

   localparam int SETTLE_CYC = cyc_up(TP1_MIN_MS);
   localparam int SETTLE_MAX_CYC = cyc_up(TP1_MAX_MS);
   localparam int BL_ON_CYC = cyc_up(TP2_MIN_MS);
   localparam int OFF_CYC = cyc_up(TP3_MIN_MS);
   localparam int BL_OFF_CYC = cyc_up(TP4_MIN_MS);
   localparam int LOCK_CYC = cyc_up(LOCK_MAX_MS);
   localparam int CNT_W = 25;

   // ----------------------------------------------------------------
   // pixel slot layout on the serializer lanes
   // ----------------------------------------------------------------
   localparam int COLOR_W = 8;
   localparam int LANE_W = 7;
   localparam int LANE2_DE_BIT = 4;
   localparam int LANE3_RSV_BIT = 6;
   localparam int DIM_W = 8;

endpackage

// [src/lvs_lane_pack.sv]
// maps one pixel colour and its qualifier onto the four lane slots
`timescale 1ns/1ps
module lvs_lane_pack
   import lvs_pkg::*;
(
   // pixel in
   input wire logic [3*COLOR_W-1:0] color,
   input wire logic pixelValid,
   input wire logic depth8,
   // lane slots out, bit 0 goes first
   output logic [LANE_W-1:0] lane0,
   output logic [LANE_W-1:0] lane1,
   output logic [LANE_W-1:0] lane2,
   output logic [LANE_W-1:0] lane3
);
   logic [COLOR_W-1:0] red;
   logic [COLOR_W-1:0] grn;
   logic [COLOR_W-1:0] blu;
   logic [5:0] r6;
   logic [5:0] g6;
   logic [5:0] b6;

   // 6-bit mode keeps the top six bits, so dark colours stay dark
   always_comb
   begin
      red = color[3*COLOR_W-1:2*COLOR_W];
      grn = color[2*COLOR_W-1:COLOR_W];
      blu = color[COLOR_W-1:0];
      r6 = depth8 ? red[5:0] : red[7:2];
      g6 = depth8 ? grn[5:0] : grn[7:2];
      b6 = depth8 ? blu[5:0] : blu[7:2];
      lane0 = {g6[0], r6};
      lane1 = {b6[1:0], g6[5:1]};
      lane2 = {2'h0, pixelValid, b6[5:2]};
      lane3 = 7'h00;
      if (depth8)
      begin
         lane3 = {1'h0, blu[7:6], grn[7:6], red[7:6]};
      end
   end
endmodule // lvs_lane_pack

// [src/lvs_dim_pwm.sv]
// free-running pulse-width modulator for backlight dimming
`timescale 1ns/1ps
module lvs_dim_pwm
   import lvs_pkg::*;
#(
   parameter int W = DIM_W
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // control
   input wire logic enable,
   input wire logic [W-1:0] duty,
   // modulated output
   output logic pwmOut
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic pwm_ff;
   logic nxt_pwm;

   if (W < 2 || W > 16)
   begin : bad_width
      $error("dimming width out of range");
   end

   // duty of zero keeps the line low, full scale is 255 of 256
   always_comb
   begin
      nxt_cnt = cnt_ff + 1'b1;
      nxt_pwm = enable && (cnt_ff < duty);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cnt_ff <= '0;
         pwm_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         pwm_ff <= nxt_pwm;
      end
   end

   assign pwmOut = pwm_ff;
endmodule // lvs_dim_pwm

// [src/lvs_panel_host.sv]
// host controller: power order, raster and lanes for the 800x600 panel
`timescale 1ns/1ps
module lvs_panel_host
   import lvs_pkg::*;
#(
   parameter int SETTLE_C = SETTLE_CYC,
   parameter int BL_ON_C = BL_ON_CYC,
   parameter int BL_OFF_C = BL_OFF_CYC,
   parameter int OFF_C = OFF_CYC,
   parameter int LOCK_C = LOCK_CYC,
   parameter int H_ACT = H_ACTIVE,
   parameter int H_TOT = H_TOTAL,
   parameter int V_ACT = V_ACTIVE,
   parameter int V_TOT = V_TOTAL
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // user orders
   input wire logic powerOn,
   input wire logic scanReverseCfg,
   input wire logic colorDepthCfg,
   input wire logic [DIM_W-1:0] dimDuty,
   input wire logic [3*COLOR_W-1:0] pixelColor,
   // user status and pixel fetch
   output logic pixReq,
   output logic [X_W-1:0] pixX,
   output logic [Y_W-1:0] pixY,
   output logic displayValid,
   // panel supply
   output logic supplyEn,
   input wire logic supplyGood,
   // panel straps and backlight
   output logic scanReverseStrap,
   output logic colorDepthStrap,
   output logic backlightEn,
   output logic dimPwm,
   // serializer side
   output logic pixelClock,
   output logic pixelValidQualifier,
   output logic [LANE_W-1:0] laneWord0,
   output logic [LANE_W-1:0] laneWord1,
   output logic [LANE_W-1:0] laneWord2,
   output logic [LANE_W-1:0] laneWord3
);
   // ----------------------------------------------------------------
   // configuration checks
   // ----------------------------------------------------------------
   if (PCLK_DIV * MCLK_PS < PCLK_MIN_PS ||
       PCLK_DIV * MCLK_PS > PCLK_MAX_PS)
   begin : bad_pclk
      $error("pixel clock divider out of range");
   end
   if (H_ACT != H_ACTIVE || V_ACT != V_ACTIVE)
   begin : bad_active
      $error("active area must be 800 by 600");
   end
   if (H_TOT - H_ACT < H_BLANK_MIN || H_TOT - H_ACT > H_BLANK_MAX ||
       H_TOT < H_TOTAL_MIN || H_TOT > H_TOTAL_MAX)
   begin : bad_line
      $error("line blanking out of range");
   end
   if (V_TOT - V_ACT < V_BLANK_MIN || V_TOT - V_ACT > V_BLANK_MAX ||
       V_TOT < V_TOTAL_MIN || V_TOT > V_TOTAL_MAX)
   begin : bad_frame
      $error("frame blanking out of range");
   end
   if (longint'(H_TOT) * V_TOT * PCLK_DIV * MCLK_NS * FRAME_HZ_MAX
       < 64'd1000000000)
   begin : bad_rate
      $error("frame rate above limit");
   end
   if (SETTLE_C < 1 || SETTLE_C > SETTLE_MAX_CYC || OFF_C < 1 ||
       BL_ON_C <= LOCK_C || BL_OFF_C < 1 || LOCK_C < 1 ||
       BL_ON_C >= (1 << CNT_W) || BL_OFF_C >= (1 << CNT_W))
   begin : bad_times
      $error("power sequence counts out of range");
   end

   // inside the active window of the raster
   function automatic logic is_active(input logic [X_W-1:0] x,
                                      input logic [Y_W-1:0] y);
      is_active = (x < X_W'(H_ACT)) && (y < Y_W'(V_ACT));
   endfunction

   // ----------------------------------------------------------------
   // supply-good pin synchroniser
   // ----------------------------------------------------------------
   logic sgMeta_ff, sgMid_ff, sgLate_ff, sgLvl_ff;
   logic nxt_sgLvl;

   // level moves only once the second and third stage agree
   always_comb
   begin
      nxt_sgLvl = (sgMid_ff == sgLate_ff) ? sgLate_ff : sgLvl_ff;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sgMeta_ff <= 1'b0;
         sgMid_ff <= 1'b0;
         sgLate_ff <= 1'b0;
         sgLvl_ff <= 1'b0;
      end
      else
      begin
         sgMeta_ff <= supplyGood;
         sgMid_ff <= sgMeta_ff;
         sgLate_ff <= sgMid_ff;
         sgLvl_ff <= nxt_sgLvl;
      end
   end

   // ----------------------------------------------------------------
   // power sequencer
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {PWR_OFF, PWR_RAMP, PWR_SETTLE, PWR_VIDEO,
                             PWR_LIT, PWR_DARK, PWR_STOP, PWR_DRAIN}
      lvs_pwr_t;
   lvs_pwr_t pwr_ff, nxt_pwr;
   logic [CNT_W-1:0] seqCnt_ff, nxt_seqCnt;
   logic supplyEn_ff, nxt_supplyEn, videoRun_ff, nxt_videoRun;
   logic backlight_ff, nxt_backlight, valid_ff, nxt_valid;
   logic scanRev_ff, nxt_scanRev, depth8_ff, nxt_depth8;

   // straps only move while the panel is unpowered
   always_comb
   begin
      nxt_pwr = pwr_ff;
      nxt_seqCnt = seqCnt_ff + 1'b1;
      nxt_supplyEn = supplyEn_ff;
      nxt_videoRun = videoRun_ff;
      nxt_backlight = backlight_ff;
      nxt_valid = valid_ff;
      nxt_scanRev = scanRev_ff;
      nxt_depth8 = depth8_ff;
      unique case (pwr_ff)
         PWR_OFF:
         begin
            nxt_scanRev = scanReverseCfg;
            nxt_depth8 = colorDepthCfg;
            if (powerOn)
            begin
               nxt_pwr = PWR_RAMP;
               nxt_supplyEn = 1'b1;
            end
         end
         PWR_RAMP, PWR_SETTLE:
         begin
            if (!powerOn)
            begin
               nxt_pwr = PWR_DRAIN;
               nxt_supplyEn = 1'b0;
            end
            else if (pwr_ff == PWR_RAMP && sgLvl_ff)
            begin
               nxt_pwr = PWR_SETTLE;
               nxt_seqCnt = '0;
            end
            else if (pwr_ff == PWR_SETTLE &&
                     seqCnt_ff == CNT_W'(SETTLE_C - 1))
            begin
               nxt_pwr = PWR_VIDEO;
               nxt_videoRun = 1'b1;
               nxt_seqCnt = '0;
            end
         end
         PWR_VIDEO:
         begin
            if (seqCnt_ff == CNT_W'(LOCK_C - 1))
            begin
               nxt_valid = 1'b1;
            end
            if (!powerOn)
            begin
               nxt_pwr = PWR_STOP;
               nxt_videoRun = 1'b0;
               nxt_valid = 1'b0;
               nxt_seqCnt = '0;
            end
            else if (seqCnt_ff == CNT_W'(BL_ON_C - 1))
            begin
               nxt_pwr = PWR_LIT;
               nxt_backlight = 1'b1;
            end
         end
         PWR_LIT:
         begin
            nxt_seqCnt = '0;
            if (!powerOn)
            begin
               nxt_pwr = PWR_DARK;
               nxt_backlight = 1'b0;
            end
         end
         PWR_DARK:
         begin
            if (seqCnt_ff == CNT_W'(BL_OFF_C - 1))
            begin
               nxt_pwr = PWR_STOP;
               nxt_videoRun = 1'b0;
               nxt_valid = 1'b0;
               nxt_seqCnt = '0;
            end
         end
         PWR_STOP:
         begin
            if (seqCnt_ff == CNT_W'(OFF_C - 1))
            begin
               nxt_pwr = PWR_DRAIN;
               nxt_supplyEn = 1'b0;
            end
         end
         PWR_DRAIN:
         begin
            if (!sgLvl_ff)
            begin
               nxt_pwr = PWR_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pwr_ff <= PWR_OFF;
         seqCnt_ff <= '0;
         supplyEn_ff <= 1'b0;
         videoRun_ff <= 1'b0;
         backlight_ff <= 1'b0;
         valid_ff <= 1'b0;
         scanRev_ff <= 1'b0;
         depth8_ff <= 1'b0;
      end
      else
      begin
         pwr_ff <= nxt_pwr;
         seqCnt_ff <= nxt_seqCnt;
         supplyEn_ff <= nxt_supplyEn;
         videoRun_ff <= nxt_videoRun;
         backlight_ff <= nxt_backlight;
         valid_ff <= nxt_valid;
         scanRev_ff <= nxt_scanRev;
         depth8_ff <= nxt_depth8;
      end
   end

   // ----------------------------------------------------------------
   // raster generator, one pixel every PCLK_DIV mclk cycles
   // ----------------------------------------------------------------
   logic [1:0] ph_ff, nxt_ph;
   logic [X_W-1:0] hCnt_ff, nxt_hCnt;
   logic [Y_W-1:0] vCnt_ff, nxt_vCnt;
   logic pclk_ff, nxt_pclk, de_ff, nxt_de, req_ff, nxt_req;
   logic [LANE_W-1:0] ln0_ff, ln1_ff, ln2_ff, ln3_ff;
   logic [LANE_W-1:0] nxt_ln0, nxt_ln1, nxt_ln2, nxt_ln3;
   logic [LANE_W-1:0] pk0, pk1, pk2, pk3;
   logic tick;

   // qualifier follows the window exactly, never a free-run guess
   lvs_lane_pack u_pack (
      .color(pixelColor),
      .pixelValid(is_active(hCnt_ff, vCnt_ff)),
      .depth8(depth8_ff),
      .lane0(pk0),
      .lane1(pk1),
      .lane2(pk2),
      .lane3(pk3)
   );

   // outputs change as the clock falls; rising edge sees stable data
   always_comb
   begin
      tick = (ph_ff == 2'(PCLK_DIV - 1));
      nxt_ph = tick ? 2'h0 : ph_ff + 2'h1;
      nxt_hCnt = hCnt_ff;
      nxt_vCnt = vCnt_ff;
      nxt_de = de_ff;
      nxt_ln0 = ln0_ff;
      nxt_ln1 = ln1_ff;
      nxt_ln2 = ln2_ff;
      nxt_ln3 = ln3_ff;
      nxt_pclk = videoRun_ff && (nxt_ph != 2'h0);
      nxt_req = videoRun_ff && (ph_ff == 2'h0) && is_active(hCnt_ff, vCnt_ff);
      if (!videoRun_ff)
      begin
         nxt_ph = 2'h0;
         nxt_hCnt = '0;
         nxt_vCnt = '0;
         nxt_de = 1'b0;
         nxt_ln0 = '0;
         nxt_ln1 = '0;
         nxt_ln2 = '0;
         nxt_ln3 = '0;
      end
      else if (tick)
      begin
         nxt_de = is_active(hCnt_ff, vCnt_ff);
         nxt_ln0 = pk0;
         nxt_ln1 = pk1;
         nxt_ln2 = pk2;
         nxt_ln3 = pk3;
         nxt_hCnt = hCnt_ff + 1'b1;
         if (hCnt_ff == X_W'(H_TOT - 1))
         begin
            nxt_hCnt = '0;
            nxt_vCnt = (vCnt_ff == Y_W'(V_TOT - 1)) ? '0 : vCnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ph_ff <= 2'h0;
         hCnt_ff <= '0;
         vCnt_ff <= '0;
         pclk_ff <= 1'b0;
         de_ff <= 1'b0;
         req_ff <= 1'b0;
         ln0_ff <= '0;
         ln1_ff <= '0;
         ln2_ff <= '0;
         ln3_ff <= '0;
      end
      else
      begin
         ph_ff <= nxt_ph;
         hCnt_ff <= nxt_hCnt;
         vCnt_ff <= nxt_vCnt;
         pclk_ff <= nxt_pclk;
         de_ff <= nxt_de;
         req_ff <= nxt_req;
         ln0_ff <= nxt_ln0;
         ln1_ff <= nxt_ln1;
         ln2_ff <= nxt_ln2;
         ln3_ff <= nxt_ln3;
      end
   end

   // backlight dimming
   lvs_dim_pwm #(.W(DIM_W)) u_pwm (
      .mclk(mclk),
      .rst(rst),
      .enable(backlight_ff),
      .duty(dimDuty),
      .pwmOut(dimPwm)
   );

   assign pixReq = req_ff;
   assign pixX = hCnt_ff;
   assign pixY = vCnt_ff;
   assign displayValid = valid_ff;
   assign supplyEn = supplyEn_ff;
   assign scanReverseStrap = scanRev_ff;
   assign colorDepthStrap = depth8_ff;
   assign backlightEn = backlight_ff;
   assign pixelClock = pclk_ff;
   assign pixelValidQualifier = de_ff;
   assign laneWord0 = ln0_ff;
   assign laneWord1 = ln1_ff;
   assign laneWord2 = ln2_ff;
   assign laneWord3 = ln3_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] vidAge_ff, darkAge_ff, stopAge_ff, goodAge_ff;
   logic [X_W-1:0] deRun_ff;

   // helper ages saturate, the deRun_ff count does not; all read only by the checks below
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         vidAge_ff <= '0;
         darkAge_ff <= '0;
         stopAge_ff <= '0;
         goodAge_ff <= '0;
         deRun_ff <= '0;
      end
      else
      begin
         vidAge_ff <= !videoRun_ff ? '0 : vidAge_ff + 1'(~&vidAge_ff);
         darkAge_ff <= backlight_ff ? '0 : darkAge_ff + 1'(~&darkAge_ff);
         stopAge_ff <= videoRun_ff ? '0 : stopAge_ff + 1'(~&stopAge_ff);
         goodAge_ff <= !sgLvl_ff ? '0 : goodAge_ff + 1'(~&goodAge_ff);
         deRun_ff <= !de_ff ? '0 : deRun_ff + X_W'(tick);
      end
   end

   default clocking dc @(posedge mclk); endclocking
   default disable iff (rst);

   pclk_shape_a: assert property (videoRun_ff && $fell(pclk_ff) &&
      $past(videoRun_ff) |=> pclk_ff ##1 (pclk_ff || !videoRun_ff) ##1
      (!pclk_ff || !videoRun_ff))
      else $error("pixel clock shape wrong");
   line_active_a: assert property ($fell(de_ff) && videoRun_ff |->
      deRun_ff == X_W'(H_ACT))
      else $error("active line length wrong");
   de_lane_a: assert property (ln2_ff[LANE2_DE_BIT] == de_ff)
      else $error("qualifier missing from third lane");
   depth_lane_a: assert property (!depth8_ff |-> ln3_ff == '0)
      else $error("fourth lane busy in 6-bit mode");
   video_start_a: assert property ($rose(videoRun_ff) |->
      goodAge_ff >= CNT_W'(SETTLE_C))
      else $error("video started too early");
   backlight_delay_a: assert property ($rose(backlight_ff) |->
      vidAge_ff >= CNT_W'(BL_ON_C))
      else $error("backlight on too early");
   video_hold_a: assert property ($fell(videoRun_ff) && $past(pwr_ff)
      == PWR_DARK |-> darkAge_ff >= CNT_W'(BL_OFF_C))
      else $error("video stopped too soon after backlight");
   supply_off_a: assert property ($fell(supplyEn_ff) && $past(pwr_ff)
      == PWR_STOP |-> stopAge_ff >= CNT_W'(OFF_C))
      else $error("supply dropped too soon");
   valid_lock_a: assert property ($rose(valid_ff) |->
      vidAge_ff == CNT_W'(LOCK_C))
      else $error("display valid before lock time");
   de_blank_a: assert property (de_ff |-> $past(videoRun_ff) &&
      $past(vCnt_ff) < Y_W'(V_ACT))
      else $error("qualifier high in blanking");

   power_up_c: cover property ($rose(backlight_ff));
   power_down_c: cover property ($fell(supplyEn_ff) && $past(pwr_ff) ==
      PWR_STOP);
   frame_wrap_c: cover property (tick && vCnt_ff == Y_W'(V_TOT - 1) &&
      hCnt_ff == X_W'(H_TOT - 1));
   abort_c: cover property (pwr_ff == PWR_SETTLE && !powerOn);
endmodule // lvs_panel_host

// [verif/lvs_panel_model.sv]
// panel model: supply rail, backlight, straps and lane capture
`timescale 1ns/1ps
module lvs_panel_model
   import lvs_pkg::*;
#(
   parameter int RAMP_C = 6
)
(
   // clock and supply
   input wire logic mclk,
   input wire logic supplyEn,
   output logic supplyGood,
   // straps and backlight
   input wire logic scanReverseStrap,
   input wire logic colorDepthStrap,
   input wire logic backlightEn,
   input wire logic dimPwm,
   // link side
   input wire logic pixelClock,
   input wire logic pixelValidQualifier,
   input wire logic [LANE_W-1:0] laneWord2,
   input wire logic [LANE_W-1:0] laneWord3,
   // what the panel shows
   output logic lightOn,
   output logic scanBackward,
   output logic [DIM_W-1:0] glow,
   output logic [LANE_W-1:0] lastLane2,
   output logic [LANE_W-1:0] lastLane3,
   output int lineActive,
   output int lineTotal
);
   int ramp = 0;
   int actCnt = 0;
   int totCnt = 0;
   logic prevDe = 1'b0;
   int pwmHi = 0;

   // rail follows its enable after a ramp both ways, never at once
   always @(posedge mclk)
   begin
      if (supplyGood === supplyEn) ramp <= 0;
      else if (ramp == RAMP_C) supplyGood <= supplyEn;
      else ramp <= ramp + 1;
   end
   initial supplyGood = 1'b0;

   // light tracks enable and the rail; glow holds while lit and clears when dark, duty is only counted
   assign lightOn = backlightEn & supplyGood;
   assign scanBackward = scanReverseStrap;
   always @(posedge mclk)
   begin
      pwmHi <= dimPwm ? pwmHi + 1 : pwmHi;
      glow <= lightOn ? glow : '0;
   end

   // --------------------------------------------------------------
   // link receiver: lanes are only trusted at the pixel clock rise
   // --------------------------------------------------------------
   always @(posedge pixelClock)
   begin
      if (pixelValidQualifier)
      begin
         lastLane2 <= laneWord2;
         lastLane3 <= colorDepthStrap ? laneWord3 : 7'h00;
         actCnt <= prevDe ? actCnt + 1 : 1;
      end
      if (!pixelValidQualifier && prevDe) lineActive <= actCnt;
      if (pixelValidQualifier && !prevDe)
      begin
         lineTotal <= totCnt;
         totCnt <= 1;
      end
      else totCnt <= totCnt + 1;
      prevDe <= pixelValidQualifier;
   end
endmodule // lvs_panel_model

// [verif/lvs_panel_host_tb.sv]
// self-checking bench for the panel host controller
`timescale 1ns/1ps
module lvs_panel_host_tb;
   import lvs_pkg::*;
   localparam int SET_C = 20, LCK_C = 10, BLON_C = 40, BLOFF_C = 40;
   localparam int OFFW_C = 20;
   logic mclk = 0, rst = 1, powerOn = 0, scanReverseCfg = 0;
   logic colorDepthCfg = 0;
   logic [DIM_W-1:0] dimDuty = 8'h00;
   logic [3*COLOR_W-1:0] pixelColor = 24'hC65AE9;
   logic pixReq, displayValid, supplyEn, supplyGood, scanReverseStrap;
   logic colorDepthStrap, backlightEn, dimPwm, pixelClock, pixelValid;
   logic [X_W-1:0] pixX;
   logic [Y_W-1:0] pixY;
   logic [LANE_W-1:0] lw0, lw1, lw2, lw3, lastL2, lastL3;
   logic lightOn, scanBack;
   int lineAct, lineTot, miscompares = 0, checks_done = 0;

   always #(MCLK_NS / 2.0) mclk = ~mclk;

   lvs_panel_host #(.SETTLE_C(SET_C), .BL_ON_C(BLON_C),
      .BL_OFF_C(BLOFF_C), .OFF_C(OFFW_C), .LOCK_C(LCK_C)) dut (.mclk(mclk),
      .rst(rst), .powerOn(powerOn), .scanReverseCfg(scanReverseCfg),
      .colorDepthCfg(colorDepthCfg), .dimDuty(dimDuty),
      .pixelColor(pixelColor), .pixReq(pixReq), .pixX(pixX), .pixY(pixY),
      .displayValid(displayValid), .supplyEn(supplyEn),
      .supplyGood(supplyGood), .scanReverseStrap(scanReverseStrap),
      .colorDepthStrap(colorDepthStrap), .backlightEn(backlightEn),
      .dimPwm(dimPwm), .pixelClock(pixelClock),
      .pixelValidQualifier(pixelValid), .laneWord0(lw0), .laneWord1(lw1),
      .laneWord2(lw2), .laneWord3(lw3));

   lvs_panel_model panel (.mclk(mclk), .supplyEn(supplyEn),
      .supplyGood(supplyGood), .scanReverseStrap(scanReverseStrap),
      .colorDepthStrap(colorDepthStrap), .backlightEn(backlightEn),
      .dimPwm(dimPwm), .pixelClock(pixelClock),
      .pixelValidQualifier(pixelValid), .laneWord2(lw2), .laneWord3(lw3),
      .lightOn(lightOn), .scanBackward(scanBack), .glow(),
      .lastLane2(lastL2), .lastLane3(lastL3), .lineActive(lineAct),
      .lineTotal(lineTot));

   // --------------------------------------------------------------
   // shared helpers
   // --------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen,
            want);
      end
   endtask

   // bounded wait sampled just after each edge; n counts edges waited
   task automatic wait_lvl(ref logic s, input logic v, input int lim,
      output int n);
      n = 0;
      while (s !== v && n < lim)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      check(s, v);
   endtask

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   // power up: supply first, video, lock, then backlight much later
   task automatic power_up(input logic depth, input logic rev);
      int n;
      @(posedge mclk);
      scanReverseCfg <= rev;
      colorDepthCfg <= depth;
      powerOn <= 1'b1;
      @(posedge mclk);
      #1;
      check(supplyEn, 1'b1);
      check(pixelClock, 1'b0);
      wait_lvl(pixelClock, 1'b1, SET_C + 40, n);
      check(supplyGood, 1'b1);
      check(n >= SET_C, 1'b1);
      check(displayValid, 1'b0);
      check(backlightEn, 1'b0);
      check({scanReverseStrap, colorDepthStrap}, {rev, depth});
      check(scanBack, rev);
      wait_lvl(displayValid, 1'b1, LCK_C + 4, n);
      check(n >= LCK_C - 2, 1'b1);
      wait_lvl(backlightEn, 1'b1, BLON_C, n);
      check(n >= BLON_C - LCK_C - 4, 1'b1);
      check(lightOn, 1'b1);
   endtask

   // dimming duty: high count over one 256-cycle period
   task automatic dim_duty;
      int hi = 0;
      @(posedge mclk);
      dimDuty <= 8'h40;
      repeat (300) @(posedge mclk);
      #1;
      for (int i = 0; i < 256; i++)
      begin
         hi += (dimPwm === 1'b1);
         @(posedge mclk);
         #1;
      end
      check(hi, 64);
   endtask

   // raster, pixel clock period and lane layout over whole lines
   task automatic raster(input logic depth);
      int a;
      int b;
      logic [3*COLOR_W-1:0] c;
      c = pixelColor;
      repeat (3 * 3 * H_TOTAL + 20) @(posedge mclk);
      #1;
      check(lineAct, H_ACTIVE);
      check(lineTot, H_TOTAL);
      // start in the single low cycle so the phase cannot skew the count
      wait_lvl(pixelClock, 1'b0, 4, a);
      wait_lvl(pixelClock, 1'b1, 4, a);
      wait_lvl(pixelClock, 1'b0, 4, b);
      check(a + b, PCLK_DIV);
      if (depth)
      begin
         check(lastL2, {3'b001, c[5:2]});
         check(lastL3, {1'b0, c[7:6], c[15:14], c[23:22]});
         check(lw0, {c[8], c[21:16]});
         check(lw1, {c[1:0], c[13:9]});
      end
      else
      begin
         check(lastL2, {3'b001, c[7:4]});
         check(lw3, 7'h00);
         check(lw0, {c[10], c[23:18]});
         check(lw1, {c[3:2], c[15:11]});
      end
      // fetch requests only inside the active window, one cycle each
      wait_lvl(pixReq, 1'b1, 3 * H_TOTAL, a);
      check(pixX < H_ACTIVE && pixY < V_ACTIVE, 1'b1);
      @(posedge mclk);
      #1;
      check(pixReq, 1'b0);
   endtask

   // power down: backlight off, video stops later, supply last
   task automatic power_down;
      int n;
      @(posedge mclk);
      powerOn <= 1'b0;
      @(posedge mclk);
      #1;
      wait_lvl(backlightEn, 1'b0, 3, n);
      check(pixelClock | pixelValid | displayValid, 1'b1);
      wait_lvl(displayValid, 1'b0, BLOFF_C + 6, n);
      check(n >= BLOFF_C - 2, 1'b1);
      repeat (3) @(posedge mclk);
      #1;
      check({pixelClock, pixelValid, supplyEn}, 3'b001);
      wait_lvl(supplyEn, 1'b0, OFFW_C + 6, n);
      check(n >= OFFW_C - 4, 1'b1);
      wait_lvl(supplyGood, 1'b0, 20, n);
      // powerOn is refused until the synced rail reads low and OFF returns
      repeat (6) @(posedge mclk);
   endtask

   // power dropped during the ramp: supply off at once, no video
   task automatic power_abort;
      @(posedge mclk);
      powerOn <= 1'b1;
      repeat (2) @(posedge mclk);
      powerOn <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      check({supplyEn, pixelClock}, 2'b00);
      repeat (20) @(posedge mclk);
   endtask

   // watchdog sized from the sequence lengths above
   initial
   begin
      #400000;
      miscompares++;
      complete_run();
   end

   initial
   begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      power_abort();
      power_up(1'b1, 1'b1);
      dim_duty();
      raster(1'b1);
      power_down();
      power_up(1'b0, 1'b0);
      raster(1'b0);
      power_down();
      complete_run();
   end
endmodule // lvs_panel_host_tb
